/* rtl/imf_arbiter.sv */
// Eligibility test for one maskable request at an instruction boundary
module imf_arbiter
    import imf_pkg::*;
(
    input  wire logic CLOCK,
    input  wire logic boundary,
    imf_if.arb        lane
);
    function automatic logic above(input imf_level_type lvl, input imf_level_type thr);
        above = lvl > thr;
    endfunction
    always_comb begin
        lane.accept = lane.req_valid && boundary && lane.mask_enable
                      && above(lane.req_level, lane.threshold);
    end
endmodule // imf_arbiter

/* rtl/imf_flags.sv */
// Interrupt mask, stack select and priority threshold flags with APB access
// Overview of operation
// - Mask-enable zero blocks all maskable requests.
// - Acknowledge clears the mask-enable bit.
// - Select bit picks handler or task stack.
// - Acknowledge or trap 0..31 clears select.
// - Threshold is three bits, levels 0..7.
// - Only strictly higher level requests accepted.
// - Reserved bit reads zero; write zero.
// - Serves 14 internal, 6 external, 4 software.
`include "imf_map.svh"
module imf_flags
    import imf_pkg::*;
(
    input  wire logic                  CLOCK,
    input  wire logic                  SRST,
    input  wire logic                  PSEL,
    input  wire logic                  PENABLE,
    input  wire logic                  PWRITE,
    input  wire logic [11:0]           PADDR,
    input  wire logic [31:0]           PWDATA,
    output logic      [31:0]           PRDATA,
    output logic                       PREADY,
    output logic                       PSLVERR,
    input  wire logic                  BOUNDARY,
    input  wire logic                  REQ_VALID,
    input  wire imf_pkg::imf_level_type REQ_LEVEL,
    input  wire logic                  HW_REQ,
    input  wire logic                  TRAP_EXEC,
    input  wire imf_pkg::imf_vec_type  TRAP_NUM,
    output logic                       ACK,
    output logic                       STACK_IS_TASK,
    output logic      [15:0]           STACK_POINTER
);
    import imf_pkg::*;

    imf_if lane ();

    imf_flag_type  flag;
    imf_flag_type  next_flag;
    logic [15:0]   handler_stack_pointer;
    logic [15:0]   next_handler_stack_pointer;
    logic [15:0]   task_stack_pointer;
    logic [15:0]   next_task_stack_pointer;
    logic [31:0]   next_prdata;
    imf_event_type last_event;
    imf_event_type next_last_event;
    logic          wr;
    logic          rd;
    logic          hit;

    function automatic logic is_addr(input logic [11:0] a, input logic [11:0] off);
        is_addr = a == off;
    endfunction

    assign wr = PSEL && PENABLE && PWRITE;
    assign rd = PSEL && !PENABLE && !PWRITE;
    assign hit = is_addr(PADDR, `IMF_FLAG_OFF) || is_addr(PADDR, `IMF_REQ_OFF)
              || is_addr(PADDR, `IMF_STAT_OFF) || is_addr(PADDR, `IMF_SRC_OFF)
              || is_addr(PADDR, `IMF_SP_OFF);
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !hit;

    assign lane.mask_enable = flag[`IMF_I_BIT];
    assign lane.threshold = flag[`IMF_LVL_MSB:`IMF_LVL_LSB];
    assign lane.req_level = REQ_LEVEL;
    assign lane.req_valid = REQ_VALID;

    imf_arbiter u_arb (
        .CLOCK    (CLOCK),
        .boundary (BOUNDARY),
        .lane     (lane)
    );

    assign ACK = lane.accept;
    assign STACK_IS_TASK = flag[`IMF_U_BIT];
    assign STACK_POINTER = flag[`IMF_U_BIT] ? task_stack_pointer
                                            : handler_stack_pointer;

    always_comb begin
        next_flag = flag;
        next_handler_stack_pointer = handler_stack_pointer;
        next_task_stack_pointer = task_stack_pointer;
        next_last_event = last_event;
        // Software write first so hardware events below win
        if (wr && is_addr(PADDR, `IMF_FLAG_OFF)) begin
            next_flag = PWDATA[15:0];
            next_flag[`IMF_RSV_BIT] = 1'b0;
        end
        if (wr && is_addr(PADDR, `IMF_SP_OFF)) begin
            next_handler_stack_pointer = PWDATA[15:0];
            next_task_stack_pointer = PWDATA[31:16];
        end
        if (lane.accept || HW_REQ) begin
            next_flag[`IMF_I_BIT] = 1'b0;
            next_flag[`IMF_U_BIT] = 1'b0;
            next_last_event = IMF_ACK;
        end else if (TRAP_EXEC) begin
            if (TRAP_NUM <= `IMF_TRAP_LOW_MAX) begin
                next_flag[`IMF_U_BIT] = 1'b0;
            end
            next_last_event = IMF_TRAP;
        end
    end

    always_comb begin
        next_prdata = PRDATA;
        if (rd) begin
            case (PADDR)
                `IMF_FLAG_OFF: next_prdata = {16'h0000, flag};
                `IMF_REQ_OFF:  next_prdata = {28'h0000000, ACK, REQ_LEVEL};
                `IMF_STAT_OFF: next_prdata = {30'h00000000, last_event};
                // Source counts reported so firmware can size its tables
                `IMF_SRC_OFF:  next_prdata = {8'h00, 8'(`IMF_PRIO_LEVELS),
                                              8'(`IMF_SW_SRC), 4'(`IMF_EXT_SRC),
                                              4'(`IMF_INT_SRC)};
                `IMF_SP_OFF:   next_prdata = {task_stack_pointer, handler_stack_pointer};
                default:       next_prdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            flag <= `IMF_FLAG_RESET;
            handler_stack_pointer <= 16'h0000;
            task_stack_pointer <= 16'h0000;
            last_event <= IMF_IDLE;
            PRDATA <= 32'h00000000;
        end else begin
            flag <= next_flag;
            handler_stack_pointer <= next_handler_stack_pointer;
            task_stack_pointer <= next_task_stack_pointer;
            last_event <= next_last_event;
            PRDATA <= next_prdata;
        end
    end
endmodule // imf_flags

/* rtl/imf_if.sv */
// Acceptance lane between flag register and arbiter
interface imf_if;
    import imf_pkg::*;
    logic          mask_enable;
    imf_level_type threshold;
    imf_level_type req_level;
    logic          req_valid;
    logic          accept;
    modport flags (output mask_enable, output threshold, input accept);
    modport arb   (input mask_enable, input threshold, input req_level,
                   input req_valid, output accept);
    modport src   (output req_level, output req_valid);
endinterface

/* rtl/imf_map.svh */
// Offsets, field positions, reset values and counts of the flag logic
`ifndef IMF_MAP_SVH
`define IMF_MAP_SVH
`define IMF_FLAG_OFF       12'h000
`define IMF_REQ_OFF        12'h004
`define IMF_STAT_OFF       12'h008
`define IMF_SRC_OFF        12'h00C
`define IMF_SP_OFF         12'h010
`define IMF_I_BIT          6
`define IMF_U_BIT          7
`define IMF_LVL_LSB        12
`define IMF_LVL_MSB        14
`define IMF_RSV_BIT        15
`define IMF_FLAG_RESET     16'h0000
`define IMF_INT_SRC        14
`define IMF_EXT_SRC        6
`define IMF_SW_SRC         4
`define IMF_PRIO_LEVELS    7
`define IMF_TRAP_LOW_MAX   6'h1F
`endif

/* rtl/imf_pkg.sv */
// Types shared by the flag logic
package imf_pkg;
    typedef logic [2:0]  imf_level_type;
    typedef logic [5:0]  imf_vec_type;
    typedef logic [15:0] imf_flag_type;
    typedef enum logic [1:0] {
        IMF_IDLE,
        IMF_ACK,
        IMF_TRAP
    } imf_event_type;
endpackage

/* verif/imf_flags_assertions.sv */
// Port checker for the flag logic
module imf_flags_assertions
    import imf_pkg::*;
(
    input wire logic                   CLOCK,
    input wire logic                   SRST,
    input wire logic                   PSEL,
    input wire logic                   BOUNDARY,
    input wire logic                   REQ_VALID,
    input wire imf_pkg::imf_level_type REQ_LEVEL,
    input wire logic                   HW_REQ,
    input wire logic                   TRAP_EXEC,
    input wire imf_pkg::imf_vec_type   TRAP_NUM,
    input wire logic                   ACK,
    input wire logic                   STACK_IS_TASK
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (SRST);
    ack_cause_a: assert property (ACK |-> REQ_VALID && BOUNDARY)
        else $error("ack without request");
    ack_level_a: assert property (ACK |-> REQ_LEVEL != 3'h0)
        else $error("ack at level zero");
    ack_mask_a: assert property (ACK |=> !ACK)
        else $error("ack not masked");
    hw_mask_a: assert property (HW_REQ |=> !ACK)
        else $error("ack after hardware clear");
    ack_stack_a: assert property (ACK || HW_REQ |=> !STACK_IS_TASK)
        else $error("select kept after ack");
    trap_stack_a: assert property (TRAP_EXEC && TRAP_NUM <= 6'h1F |=> !STACK_IS_TASK)
        else $error("select kept after trap");
    trap_hold_a: assert property (TRAP_EXEC && TRAP_NUM > 6'h1F && !ACK && !HW_REQ && !PSEL |=> $stable(STACK_IS_TASK))
        else $error("high trap moved select");
    sel_hold_a: assert property (!ACK && !HW_REQ && !TRAP_EXEC && !PSEL |=> $stable(STACK_IS_TASK))
        else $error("select moved with no cause");
endmodule // imf_flags_assertions

bind imf_flags imf_flags_assertions u_chk (.*);

/* verif/imf_flags_tb_top.sv */
// Random self-checking bench for the flag logic
module imf_flags_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import imf_pkg::*;
    logic CLOCK = 1'h0, SRST = 1'h1, PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0;
    logic BOUNDARY = 1'h0, REQ_VALID = 1'h0, HW_REQ = 1'h0, TRAP_EXEC = 1'h0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0, PRDATA, rd, sp, v;
    logic PREADY, PSLVERR, ACK, STACK_IS_TASK, err, a;
    logic [15:0] STACK_POINTER, f;
    logic [1:0] ev = 2'h0;
    imf_level_type REQ_LEVEL = 3'h0;
    imf_vec_type TRAP_NUM = 6'h00;
    integer seed = 12, bad_count = 0, comparisons = 0;
    imf_flags dut (.*);
    always #2 CLOCK = ~CLOCK;
    task chk(input string n, input logic [31:0] x, input logic [31:0] y);
        comparisons++;
        if (x !== y) begin
            bad_count++;
            $display("BAD %s exp %h got %h", n, x, y);
        end
    endtask
    // One idle cycle after each transfer keeps strobes single-driven per step
    task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
        PSEL <= 1'h1;
        PWRITE <= w;
        PADDR <= ad;
        PWDATA <= d;
        @(posedge CLOCK);
        PENABLE <= 1'h1;
        do @(posedge CLOCK); while (PREADY !== 1'h1);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'h0;
        PENABLE <= 1'h0;
        @(posedge CLOCK);
    endtask
    function logic [15:0] nxt_flag(input logic [15:0] g, input logic k, input logic [31:0] r);
        if (k | (&r[5:4])) g[6] = 1'h0;
        if (k | (&r[5:4]) | (r[6] && r[13:8] <= 6'h1F)) g[7] = 1'h0;
        return g;
    endfunction
    task print_verdict;
        $display("checks %0d bad %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        #20000;
        bad_count++;
        print_verdict;
    end
    initial begin
        repeat (20) @(posedge CLOCK);
        SRST <= 1'h0;
        @(posedge CLOCK);
        apb(1'h0, 12'h000, 32'h0);
        chk("flag", 32'h0, rd);
        apb(1'h0, 12'h00C, 32'h0);
        chk("count", 32'h0007046E, rd);
        apb(1'h0, 12'h020, 32'h0);
        chk("err", 32'h1, {31'h0, err});
        repeat (60) begin
            v = $random(seed);
            f = {1'h0, v[14:0]};
            sp = $random(seed);
            apb(1'h1, 12'h010, sp);
            apb(1'h1, 12'h000, {16'h0, f});
            chk("sel", {31'h0, f[7]}, {31'h0, STACK_IS_TASK});
            chk("sp", {16'h0, f[7] ? sp[31:16] : sp[15:0]}, {16'h0, STACK_POINTER});
            v = $random(seed);
            REQ_VALID <= |v[1:0];
            BOUNDARY <= |v[3:2];
            HW_REQ <= &v[5:4];
            TRAP_EXEC <= v[6];
            TRAP_NUM <= v[13:8];
            REQ_LEVEL <= v[16:14];
            a = (|v[1:0]) & (|v[3:2]) & f[6] & (v[16:14] > f[14:12]);
            #1 chk("ack", {31'h0, a}, {31'h0, ACK});
            @(posedge CLOCK);
            REQ_VALID <= 1'h0;
            HW_REQ <= 1'h0;
            TRAP_EXEC <= 1'h0;
            apb(1'h0, 12'h000, 32'h0);
            chk("flag", {16'h0, nxt_flag(f, a, v)}, {16'h0, rd[15:0]});
            if (a | (&v[5:4])) ev = 2'h1;
            else if (v[6]) ev = 2'h2;
            apb(1'h0, 12'h008, 32'h0);
            chk("event", {30'h0, ev}, rd);
            apb(1'h0, 12'h004, 32'h0);
            chk("req", {29'h0, v[16:14]}, rd);
        end
        print_verdict;
    end
endmodule // imf_flags_tb_top
